// file: design/adcct_top.sv
// converter timing and sequencing with an AXI4-Lite register slave
//
// Local design decisions: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
module adcct_top import adcct_pkg::*; #(
   parameter int CAL_PERIODS = CAL_PERIODS_DEF
) (
   // clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // register bus
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // analog front end
   input  wire adcct_sample_type  sample_in,
   // converter status
   output logic [15:0]            result,
   output logic                   conv_busy,
   output logic                   cal_busy,
   output logic                   conv_done
);

   if (CAL_PERIODS < 1 || CAL_PERIODS >= (1 << CAL_W)) begin : g_bad_cal
      $error("CAL_PERIODS out of range");
   end

   localparam logic [CAL_W-1:0] CAL_LAST = CAL_W'(CAL_PERIODS - 1);

   adcct_state_type s_q;
   adcct_state_type s_d;

   logic        tick;
   logic        wr_fire;
   logic        start;
   logic [15:0] ctrl_new;
   logic [9:0]  sat_code;

   always_comb begin
      s_d      = s_q;
      s_d.eoc  = 1'b0;
      wr_fire  = s_q.aw_have && s_q.w_have && !s_q.bvalid;
      ctrl_new = s_q.ctrl;
      start    = 1'b0;
      tick     = (s_q.presc == s_q.div - 5'h01);

      // inputs outside the reference range clamp to the end codes
      if (sample_in.below) begin
         sat_code = RES_ZERO;
      end else if (sample_in.above) begin
         sat_code = RES_FULL;
      end else begin
         sat_code = sample_in.code;
      end

      // write channels are taken independently, in either order
      if (s_axi_awvalid && s_q.awready) begin
         s_d.aw_have = 1'b1;
         s_d.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_q.wready) begin
         s_d.w_have = 1'b1;
         s_d.wdata  = s_axi_wdata;
         s_d.wstrb  = s_axi_wstrb;
      end
      if (wr_fire) begin
         s_d.aw_have = 1'b0;
         s_d.w_have  = 1'b0;
         s_d.bvalid  = 1'b1;
         s_d.bresp   = RESP_OKAY;
         case (s_q.awaddr)
            OFS_CONTROL: begin
               if (s_q.wstrb[0]) begin
                  ctrl_new[7:0] = s_q.wdata[7:0];
               end
               if (s_q.wstrb[1]) begin
                  ctrl_new[15:8] = s_q.wdata[15:8];
               end
               // start is ignored while a conversion runs
               start = s_q.wstrb[0] && s_q.wdata[CTL_START] && !s_q.busy;
               ctrl_new[CTL_START] = 1'b0;
               s_d.ctrl = ctrl_new;
            end
            OFS_STATUS, OFS_RESULT: begin
            end
            default: begin
               s_d.bresp = RESP_SLVERR;
            end
         endcase
      end else if (s_q.bvalid && s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      s_d.awready = !s_d.aw_have && !s_d.bvalid;
      s_d.wready  = !s_d.w_have && !s_d.bvalid;

      // read channel: one read at a time, answer one cycle after address
      if (s_axi_arvalid && s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = RESP_OKAY;
         s_d.rdata  = 32'h0000_0000;
         case (s_axi_araddr)
            OFS_CONTROL: s_d.rdata[15:0] = s_q.ctrl;
            OFS_STATUS: begin
               s_d.rdata[STA_BUSY] = s_q.busy;
               s_d.rdata[STA_CAL]  = s_q.cal_busy;
            end
            OFS_RESULT:  s_d.rdata[15:0] = s_q.result;
            default:     s_d.rresp = RESP_SLVERR;
         endcase
      end else if (s_q.rvalid && s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      s_d.arready = !s_d.rvalid;

      // basic clock prescaler, restarted with each conversion
      s_d.presc = tick ? 5'h00 : s_q.presc + 5'h01;

      case (s_q.phase)
         PH_IDLE: begin
            // divisor follows the control word while idle so calibration keeps pace
            s_d.div = div_of(s_q.ctrl[CTL_BCSEL_HI:CTL_BCSEL_LO]);
            if (s_q.cal_busy && tick) begin
               if (s_q.cal_cnt == CAL_LAST) begin
                  s_d.cal_busy = 1'b0;
               end else begin
                  s_d.cal_cnt = s_q.cal_cnt + 1'b1;
               end
            end
            if (start) begin
               // settings are frozen for the whole conversion
               s_d.div   = div_of(ctrl_new[CTL_BCSEL_HI:CTL_BCSEL_LO]);
               s_d.samp  = samp_of(ctrl_new[CTL_STSEL_HI:CTL_STSEL_LO]);
               s_d.chan  = ctrl_new[CTL_CHAN_HI:CTL_CHAN_LO];
               s_d.presc = 5'h00;
               s_d.cnt   = 7'h00;
               s_d.cal_cnt = s_q.cal_cnt;
               s_d.cal_busy = s_q.cal_busy;
               s_d.busy  = 1'b1;
               s_d.phase = PH_SAMPLE;
            end
         end
         PH_SAMPLE: begin
            if (tick) begin
               if (s_q.cnt == s_q.samp - 7'h01) begin
                  s_d.held  = sat_code;
                  s_d.cnt   = 7'h00;
                  s_d.phase = PH_DECIDE;
               end else begin
                  s_d.cnt = s_q.cnt + 7'h01;
               end
            end
         end
         PH_DECIDE: begin
            if (tick) begin
               if (s_q.cnt == DECIDE_PERIODS - 7'h01) begin
                  s_d.lcnt  = 2'h0;
                  s_d.phase = PH_LOAD;
               end else begin
                  s_d.cnt = s_q.cnt + 7'h01;
               end
            end
         end
         PH_LOAD: begin
            if (s_q.lcnt == LOAD_CYCLES - 2'h1) begin
               // only place the result register is written
               s_d.result = {s_q.chan, 2'h0, s_q.held};
               s_d.eoc    = 1'b1;
               s_d.busy   = 1'b0;
               s_d.phase  = PH_IDLE;
            end else begin
               s_d.lcnt = s_q.lcnt + 2'h1;
            end
         end
         default: begin
            s_d.phase = PH_IDLE;
            s_d.busy  = 1'b0;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q          <= '0;
         s_q.ctrl     <= CONTROL_RESET;
         s_q.div      <= 5'h04;
         s_q.cal_busy <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign s_axi_awready = s_q.awready;
   assign s_axi_wready  = s_q.wready;
   assign s_axi_bvalid  = s_q.bvalid;
   assign s_axi_bresp   = s_q.bresp;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rvalid  = s_q.rvalid;
   assign s_axi_rresp   = s_q.rresp;
   assign s_axi_rdata   = s_q.rdata;
   assign result        = s_q.result;
   assign conv_busy     = s_q.busy;
   assign cal_busy      = s_q.cal_busy;
   assign conv_done     = s_q.eoc;

   // cycles spent busy, checked against the fixed conversion length
   logic [15:0] len_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         len_q <= 16'h0000;
      end else if (s_q.busy) begin
         len_q <= len_q + 16'h0001;
      end else begin
         len_q <= 16'h0000;
      end
   end

   // last basic period of the sample phase: the input is held at this edge
   logic capture;
   assign capture = s_q.phase == PH_SAMPLE && tick && s_q.cnt == s_q.samp - 7'h01;

   // cycles since the last capture; a counter, since the wait is too long for a delay range
   logic [10:0] since_cap_q;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         since_cap_q <= 11'h000;
      end else if (capture) begin
         since_cap_q <= 11'h000;
      end else if (since_cap_q != 11'h7FF) begin
         since_cap_q <= since_cap_q + 11'h001;
      end
   end

   property p_div_sel;
      @(posedge aclk) disable iff (!aresetn)
      $rose(s_q.busy) |-> s_q.div == div_of(s_q.ctrl[CTL_BCSEL_HI:CTL_BCSEL_LO]);
   endproperty
   a_div_sel: assert property (p_div_sel) else $error("divisor does not match select");

   property p_samp_sel;
      @(posedge aclk) disable iff (!aresetn)
      $rose(s_q.busy) |-> s_q.samp == samp_of(s_q.ctrl[CTL_STSEL_HI:CTL_STSEL_LO]);
   endproperty
   a_samp_sel: assert property (p_samp_sel) else $error("sample length does not match select");

   property p_conv_len;
      @(posedge aclk) disable iff (!aresetn)
      $fell(s_q.busy) |-> $past(len_q) + 16'h0001 ==
         16'(s_q.div) * (16'(s_q.samp) + 16'(DECIDE_PERIODS)) + 16'(LOAD_CYCLES);
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

   property p_result_at_end;
      @(posedge aclk) disable iff (!aresetn)
      $changed(s_q.result) |-> s_q.eoc && $past(s_q.phase) == PH_LOAD;
   endproperty
   a_result_at_end: assert property (p_result_at_end) else $error("result changed mid conversion");

   property p_cal_end;
      @(posedge aclk) disable iff (!aresetn)
      $fell(s_q.cal_busy) |-> $past(s_q.cal_cnt) == CAL_LAST && !s_q.busy;
   endproperty
   a_cal_end: assert property (p_cal_end) else $error("calibration ended early");

   property p_cal_pause;
      @(posedge aclk) disable iff (!aresetn)
      s_q.busy && s_q.cal_busy |=> $stable(s_q.cal_cnt) && s_q.cal_busy;
   endproperty
   a_cal_pause: assert property (p_cal_pause) else $error("calibration advanced during conversion");

   property p_saturate;
      @(posedge aclk) disable iff (!aresetn)
      capture && sample_in.above && !sample_in.below |=> s_q.held == RES_FULL;
   endproperty
   a_saturate: assert property (p_saturate) else $error("over range not saturated");

   property p_load_held;
      @(posedge aclk) disable iff (!aresetn)
      s_q.eoc |-> s_q.result[9:0] == s_q.held &&
         since_cap_q == 11'(DECIDE_PERIODS) * 11'(s_q.div) + 11'(LOAD_CYCLES);
   endproperty
   a_load_held: assert property (p_load_held) else $error("result not the held sample at the fixed time");

   property p_hold;
      @(posedge aclk) disable iff (!aresetn)
      s_q.phase == PH_DECIDE |=> $stable(s_q.held);
   endproperty
   a_hold: assert property (p_hold) else $error("held sample changed after sampling");

   property p_tick_period;
      @(posedge aclk) disable iff (!aresetn)
      s_q.busy && tick && s_q.div == 5'h04 |=> !tick [*3] ##1 tick;
   endproperty
   a_tick_period: assert property (p_tick_period) else $error("prescaler period wrong");

   c_conv: cover property (@(posedge aclk) disable iff (!aresetn) s_q.eoc);
   c_conv_in_cal: cover property (@(posedge aclk) disable iff (!aresetn) s_q.eoc && s_q.cal_busy);
   c_cal_done: cover property (@(posedge aclk) disable iff (!aresetn) $fell(s_q.cal_busy));
   c_full: cover property (@(posedge aclk) disable iff (!aresetn) s_q.eoc && s_q.result[9:0] == RES_FULL);

endmodule // adcct_top

// file: pkg/adcct_pkg.sv
// constants, encodings and state layout of the converter timing block
//
// Overview of operation
// - basic clock is the CPU clock divided by 4, 2, 16 or 8 per bits 15:14.
// - sample time is 8, 16, 32 or 64 basic clock periods per bits 13:12.
// - every conversion lasts exactly sample time plus 40 basic periods plus 2 CPU cycles.
// - conversion covers sample, decide and load; result register changes only at the end.
// - after reset a calibration runs for 3328 basic clock periods.
// - conversions during calibration run normally and stretch calibration by their length.
// - input below ground gives result 000h, above reference gives 3FFh in the low ten bits.
// - the input is held at the end of sample time; later changes have no effect.
package adcct_pkg;

   // register map (byte addresses)
   localparam int          ADDR_W          = 4;
   localparam logic [3:0]  OFS_CONTROL     = 4'h0;
   localparam logic [3:0]  OFS_STATUS      = 4'h4;
   localparam logic [3:0]  OFS_RESULT      = 4'h8;
   localparam logic [15:0] CONTROL_RESET   = 16'h0000;

   // control fields
   localparam int          CTL_BCSEL_HI    = 15;
   localparam int          CTL_BCSEL_LO    = 14;
   localparam int          CTL_STSEL_HI    = 13;
   localparam int          CTL_STSEL_LO    = 12;
   localparam int          CTL_START       = 7;
   localparam int          CTL_CHAN_HI     = 3;
   localparam int          CTL_CHAN_LO     = 0;

   // status fields
   localparam int          STA_BUSY        = 0;
   localparam int          STA_CAL         = 1;

   // result fields
   localparam int          RES_CHAN_LO     = 12;
   localparam logic [9:0]  RES_ZERO        = 10'h000;
   localparam logic [9:0]  RES_FULL        = 10'h3FF;

   // timing counts
   localparam logic [6:0]  DECIDE_PERIODS  = 7'h28;
   localparam logic [1:0]  LOAD_CYCLES     = 2'h2;
   localparam int          CAL_PERIODS_DEF = 3328;
   localparam int          CAL_W           = 16;

   // answers
   localparam logic [1:0]  RESP_OKAY       = 2'h0;
   localparam logic [1:0]  RESP_SLVERR     = 2'h2;

   typedef enum logic [1:0] {PH_IDLE, PH_SAMPLE, PH_DECIDE, PH_LOAD} adcct_phase_type;

   // analog front end as seen by the timing logic
   typedef struct packed {
      logic       below;
      logic       above;
      logic [9:0] code;
   } adcct_sample_type;

   typedef struct packed {
      logic [15:0]       ctrl;
      adcct_phase_type   phase;
      logic [4:0]        presc;
      logic [4:0]        div;
      logic [6:0]        samp;
      logic [6:0]        cnt;
      logic [1:0]        lcnt;
      logic [9:0]        held;
      logic [3:0]        chan;
      logic [15:0]       result;
      logic              eoc;
      logic              busy;
      logic              cal_busy;
      logic [CAL_W-1:0]  cal_cnt;
      logic              aw_have;
      logic [ADDR_W-1:0] awaddr;
      logic              w_have;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arready;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
   } adcct_state_type;

   // prescaler divisor for a basic clock select code
   function automatic logic [4:0] div_of(input logic [1:0] sel);
      case (sel)
         2'h0:    div_of = 5'h04;
         2'h1:    div_of = 5'h02;
         2'h2:    div_of = 5'h10;
         default: div_of = 5'h08;
      endcase
   endfunction

   // sample length in basic periods for a sample time select code
   function automatic logic [6:0] samp_of(input logic [1:0] sel);
      case (sel)
         2'h0:    samp_of = 7'h08;
         2'h1:    samp_of = 7'h10;
         2'h2:    samp_of = 7'h20;
         default: samp_of = 7'h40;
      endcase
   endfunction

endpackage

// file: verification/adcct_top_tb.sv
// self-checking bench for the converter timing block
`timescale 1ns/100ps
module adcct_top_tb import adcct_pkg::*; ;
   localparam int CAL_P = 4;
   localparam int LIMIT = 30000;
   logic                   aclk = 1'b0;
   logic                   aresetn = 1'b0;
   logic [ADDR_W-1:0]      s_axi_awaddr = '0, s_axi_araddr = '0;
   logic                   s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic                   s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0]            s_axi_wdata = '0;
   logic [3:0]             s_axi_wstrb = '0;
   logic                   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]             s_axi_bresp, s_axi_rresp;
   logic [31:0]            s_axi_rdata;
   adcct_sample_type       sample_in = '0;
   logic [15:0]            result, prev_res = '0;
   logic                   conv_busy, cal_busy, conv_done, prev_done = 1'b0;
   int                     mismatches = 0, comparisons = 0, cycles = 0, run_len = 0, last_len = 0;
   int                     divs [4] = '{4, 2, 16, 8};
   int                     samps [4] = '{8, 16, 32, 64};

   always #2.5 aclk = ~aclk;

   adcct_top #(.CAL_PERIODS(CAL_P)) i_adcct_top (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sample_in(sample_in),
      .result(result), .conv_busy(conv_busy), .cal_busy(cal_busy), .conv_done(conv_done));

   task automatic close_out();
      if (mismatches == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic fail(input string msg);
      mismatches++;
      $display("ERROR at %0t: %s", $time, msg);
   endtask

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
      comparisons++;
      if (got !== exp) fail($sformatf("%s got %h expected %h", what, got, exp));
   endtask

   task automatic chk_cnt(input int got, input int exp, input string what);
      comparisons++;
      if (got != exp) fail($sformatf("%s got %0d expected %0d", what, got, exp));
   endtask

   // busy length, one-cycle done pulse, result moving only with done, watchdog
   always @(posedge aclk) begin
      if (conv_busy === 1'b1) begin
         run_len <= run_len + 1;
      end else if (run_len != 0) begin
         last_len <= run_len;
         run_len <= 0;
      end
      if (aresetn === 1'b1 && result !== prev_res && conv_done !== 1'b1) fail("result moved without done");
      if (conv_done === 1'b1 && prev_done === 1'b1) fail("done longer than one cycle");
      prev_res <= result;
      prev_done <= conv_done;
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         fail("timeout");
         close_out();
      end
   end

   // address and data offered together, each released when taken
   task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (!aw_done && s_axi_awready === 1'b1) begin
            aw_done = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (!w_done && s_axi_wready === 1'b1) begin
            w_done = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask

   task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      axi_read(a, d, r);
      chk_val({30'h0, r}, {30'h0, er}, "read response");
      if (er === RESP_OKAY) chk_val(d, exp, "read data");
   endtask

   // start a conversion, flip the input after sampling, judge length and result
   task automatic conv(input logic [1:0] bc, input logic [1:0] st, input logic [3:0] ch,
                       input adcct_sample_type s, input logic [9:0] exp);
      logic [1:0] r;
      @(posedge aclk);
      sample_in <= s;
      axi_write(OFS_CONTROL, {16'h0, bc, st, 4'h0, 1'b1, 3'h0, ch}, 4'h3, r);
      chk_val({30'h0, r}, {30'h0, RESP_OKAY}, "start response");
      repeat (divs[bc] * samps[st] + 4) @(posedge aclk);
      sample_in.code <= ~s.code;
      do @(posedge aclk); while (conv_done !== 1'b1);
      #1;
      chk_cnt(last_len, divs[bc] * (samps[st] + 40) + 2, "busy length");
      chk_val({16'h0, result}, {16'h0, ch, 2'b00, exp}, "result");
   endtask

   task automatic sc_reset();
      chk_val({31'h0, cal_busy}, 32'h1, "cal busy after reset");
      rd_chk(OFS_CONTROL, {16'h0, CONTROL_RESET}, RESP_OKAY);
      rd_chk(OFS_RESULT, 32'h0, RESP_OKAY);
   endtask

   task automatic sc_cal();
      conv(2'h0, 2'h0, 4'h3, '{below: 1'b0, above: 1'b0, code: 10'h2A5}, 10'h2A5);
      chk_val({31'h0, cal_busy}, 32'h1, "cal still busy after conversion");
      repeat (CAL_P * 4 + 4) @(posedge aclk);
      chk_val({31'h0, cal_busy}, 32'h0, "cal ended");
      rd_chk(OFS_STATUS, 32'h0, RESP_OKAY);
   endtask

   task automatic sc_regs();
      logic [1:0] r;
      axi_write(OFS_CONTROL, 32'h0000_0000, 4'h1, r);
      axi_write(OFS_CONTROL, 32'h0000_A57F, 4'h2, r);
      rd_chk(OFS_CONTROL, 32'h0000_A500, RESP_OKAY);
      axi_write(OFS_CONTROL, 32'hFFFF_FF6C, 4'h1, r);
      rd_chk(OFS_CONTROL, 32'h0000_A56C, RESP_OKAY);
      axi_write(OFS_STATUS, 32'hFFFF_FFFF, 4'hF, r);
      chk_val({30'h0, r}, {30'h0, RESP_OKAY}, "read-only write response");
      rd_chk(OFS_STATUS, 32'h0, RESP_OKAY);
      axi_write(4'hC, 32'h0000_1234, 4'hF, r);
      chk_val({30'h0, r}, {30'h0, RESP_SLVERR}, "unmapped write response");
      rd_chk(4'hC, 32'h0, RESP_SLVERR);
      rd_chk(OFS_CONTROL, 32'h0000_A56C, RESP_OKAY);
   endtask

   // every divider code against every sample code
   task automatic sc_timing();
      for (int b = 0; b < 4; b++) begin
         for (int t = 0; t < 4; t++) begin
            conv(b[1:0], t[1:0], {b[1:0], t[1:0]}, '{below: 1'b0, above: 1'b0, code: 10'h155 ^ (b * 4 + t)},
                 10'h155 ^ (b * 4 + t));
         end
      end
   endtask

   task automatic sc_sat();
      conv(2'h1, 2'h0, 4'h5, '{below: 1'b1, above: 1'b0, code: 10'h1C3}, RES_ZERO);
      conv(2'h1, 2'h0, 4'h6, '{below: 1'b0, above: 1'b1, code: 10'h0A1}, RES_FULL);
      conv(2'h1, 2'h0, 4'h7, '{below: 1'b1, above: 1'b1, code: 10'h2F0}, RES_ZERO);
   endtask

   // a second start while busy must not restart or stretch the conversion
   task automatic sc_busy();
      logic [1:0] r;
      @(posedge aclk);
      sample_in <= '{below: 1'b0, above: 1'b0, code: 10'h0F3};
      axi_write(OFS_CONTROL, 32'h0000_5089, 4'h3, r);
      rd_chk(OFS_STATUS, 32'h1, RESP_OKAY);
      axi_write(OFS_CONTROL, 32'h0000_5089, 4'h3, r);
      do @(posedge aclk); while (conv_done !== 1'b1);
      #1;
      chk_cnt(last_len, 2 * (16 + 40) + 2, "busy length with second start");
      repeat (10) @(posedge aclk);
      chk_val({31'h0, conv_busy}, 32'h0, "no restart");
      rd_chk(OFS_RESULT, {16'h0, 4'h9, 2'b00, 10'h0F3}, RESP_OKAY);
   endtask

   initial begin
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      #1;
      sc_reset();
      sc_cal();
      sc_regs();
      sc_timing();
      sc_sat();
      sc_busy();
      close_out();
   end
endmodule // adcct_top_tb
